// >>> design/basic_timer.sv
// Basic 16-bit timer with APB register slave
//
// The APB register port was decided locally.
module basic_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trigger_pin,
    input wire logic cascade_input,
    output logic complementary_out_a,
    output logic complementary_out_b,
    output logic wrap_irq,
    output logic trigger_irq,
    output logic top_irq,
    output logic dma_wrap_req,
    output logic dma_trigger_req
);
    basic_timer_pkg::basic_control_t ctrl, next_ctrl;
    logic [15:0] reload_limit, next_reload_limit;
    logic [15:0] count_value, next_count_value;
    logic [2:0] filter_sel, next_filter_sel;
    logic [2:0] irq_enable, next_irq_enable;
    logic [2:0] flags, next_flags;
    logic [1:0] dma_en, next_dma_en;
    logic [15:0] prescale_value, next_prescale_value;
    logic [15:0] pre_cnt, next_pre_cnt;
    logic started, next_started;
    logic tog, next_tog;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_out_a, next_out_b;
    logic next_dma_wrap, next_dma_trig;

    // Pin and cascade synchronisers
    // Both inputs are asynchronous to pclk; only the second stage feeds
    // the logic, so a metastable first stage never spreads.
    logic pin_s1, pin_s2, cas_s1, cas_s2;
    logic next_pin_s1, next_pin_s2, next_cas_s1, next_cas_s2;
    always_comb begin
        next_pin_s1 = ext_trigger_pin;
        next_pin_s2 = pin_s1;
        next_cas_s1 = cascade_input;
        next_cas_s2 = cas_s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            cas_s1 <= 1'b0;
            cas_s2 <= 1'b0;
        end else begin
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
            cas_s1 <= next_cas_s1;
            cas_s2 <= next_cas_s2;
        end
    end

    // Glitch filter on the pin
    logic [3:0] slow_cnt, next_slow_cnt;
    logic [2:0] same_cnt, next_same_cnt;
    logic pin_filt, next_pin_filt;
    logic sample_en;
    logic [2:0] need;
    // Counts samples that differ from the passed level; one sample that
    // matches it again restarts the count, so short glitches are dropped.
    always_comb begin
        case (filter_sel)
            3'd1: need = 3'd2;
            3'd2, 3'd4, 3'd6: need = 3'd4;
            default: need = 3'd6;
        endcase
        if (filter_sel[2:1] == 2'b10) begin
            sample_en = slow_cnt[1:0] == basic_timer_pkg::slow_div4[1:0];
        end else if (filter_sel[2:1] == 2'b11) begin
            sample_en = slow_cnt == basic_timer_pkg::slow_div16;
        end else begin
            sample_en = 1'b1;
        end
        next_slow_cnt = slow_cnt + 4'd1;
        next_same_cnt = same_cnt;
        next_pin_filt = pin_filt;
        if (filter_sel == 3'd0) begin
            next_pin_filt = pin_s2;
            next_same_cnt = 3'd0;
        end else if (sample_en) begin
            if (pin_s2 == pin_filt) begin
                next_same_cnt = 3'd0;
            end else if (same_cnt + 3'd1 >= need) begin
                next_pin_filt = pin_s2;
                next_same_cnt = 3'd0;
            end else begin
                next_same_cnt = same_cnt + 3'd1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt <= 4'h0;
            same_cnt <= 3'd0;
            pin_filt <= 1'b0;
        end else begin
            slow_cnt <= next_slow_cnt;
            same_cnt <= next_same_cnt;
            pin_filt <= next_pin_filt;
        end
    end

    // Trigger source selection and polarity
    // The edge register resets to the idle source level, so no false
    // edge follows reset; a polarity change can look like an edge, so
    // polarity must be set while the counter is stopped.
    logic src_level, src_prev, src_edge, pin_active, next_src_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= next_src_prev;
        end
    end
    always_comb begin
        src_level = (ctrl.source_select ? cas_s2 : pin_filt)
            ^ ctrl.edge_level_select;
        src_edge = src_level & ~src_prev;
        pin_active = pin_filt ^ ctrl.edge_level_select;
        next_src_prev = src_level;
    end

    // Counting core
    logic bus_wr, bus_rd, src_tick, pre_tick, cnt_wr, trig_start;
    logic wrap, top;
    always_comb begin
        bus_wr = psel && penable && pwrite && !pready;
        bus_rd = psel && penable && !pwrite && !pready;
        next_started = started;
        trig_start = 1'b0;
        if (ctrl.mode != basic_timer_pkg::mode_trigger || !ctrl.run) begin
            next_started = 1'b0;
        end else if (!started && src_edge) begin
            next_started = 1'b1;
            trig_start = 1'b1;
        end
        case (ctrl.mode)
            basic_timer_pkg::mode_timer: src_tick = 1'b1;
            basic_timer_pkg::mode_counter: src_tick = src_edge;
            basic_timer_pkg::mode_trigger: src_tick = started;
            basic_timer_pkg::mode_gated: src_tick = pin_active;
            default: src_tick = 1'b0;
        endcase
        src_tick = src_tick && ctrl.run;
        next_pre_cnt = pre_cnt;
        pre_tick = 1'b0;
        if (src_tick) begin
            if (ctrl.mode == basic_timer_pkg::mode_counter) begin
                // A prescale of zero acts as one
                if (pre_cnt + 16'd1 >= prescale_value) begin
                    pre_tick = 1'b1;
                    next_pre_cnt = 16'd0;
                end else begin
                    next_pre_cnt = pre_cnt + 16'd1;
                end
            end else if (pre_cnt >= prescale_value) begin
                pre_tick = 1'b1;
                next_pre_cnt = 16'd0;
            end else begin
                next_pre_cnt = pre_cnt + 16'd1;
            end
        end
        if (!ctrl.run) begin
            next_pre_cnt = 16'd0;
        end
        cnt_wr = bus_wr && paddr == basic_timer_pkg::count_value_addr;
        wrap = pre_tick && count_value == reload_limit;
        top = pre_tick && count_value == 16'hffff;
        next_count_value = count_value;
        next_tog = tog;
        // A bus write to the count wins over a tick in the same cycle
        if (cnt_wr) begin
            next_count_value = pwdata[15:0];
        end else if (wrap) begin
            next_count_value = 16'h0000;
            next_tog = ~tog;
        end else if (pre_tick) begin
            next_count_value = count_value + 16'd1;
        end
    end

    // Register file
    always_comb begin
        next_ctrl = ctrl;
        next_reload_limit = reload_limit;
        next_filter_sel = filter_sel;
        next_irq_enable = irq_enable;
        next_dma_en = dma_en;
        next_prescale_value = prescale_value;
        next_flags = flags;
        next_prdata = 32'h0000_0000;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        if (bus_wr) begin
            case (paddr)
                basic_timer_pkg::reload_limit_addr:
                    next_reload_limit = pwdata[15:0];
                basic_timer_pkg::count_value_addr: ;
                basic_timer_pkg::filter_control_addr:
                    next_filter_sel = pwdata[basic_timer_pkg::filter_lsb +: 3];
                basic_timer_pkg::basic_control_addr:
                    next_ctrl = pwdata[6:0];
                basic_timer_pkg::irq_enable_addr:
                    next_irq_enable = pwdata[2:0];
                basic_timer_pkg::event_flags_addr: ;
                basic_timer_pkg::event_flag_clear_addr:
                    next_flags = flags & pwdata[2:0];
                basic_timer_pkg::dma_request_enable_addr:
                    next_dma_en = pwdata[1:0];
                basic_timer_pkg::prescale_value_addr:
                    next_prescale_value = pwdata[15:0];
                default: next_pslverr = 1'b1;
            endcase
        end
        if (bus_rd) begin
            case (paddr)
                basic_timer_pkg::reload_limit_addr:
                    next_prdata = {16'h0000, reload_limit};
                basic_timer_pkg::count_value_addr:
                    next_prdata = {16'h0000, count_value};
                basic_timer_pkg::filter_control_addr:
                    next_prdata = {25'h0, filter_sel, 4'h0};
                basic_timer_pkg::basic_control_addr:
                    next_prdata = {25'h0, ctrl};
                basic_timer_pkg::irq_enable_addr:
                    next_prdata = {29'h0, irq_enable};
                basic_timer_pkg::event_flags_addr:
                    next_prdata = {29'h0, flags};
                basic_timer_pkg::event_flag_clear_addr:
                    next_prdata = {29'h0, basic_timer_pkg::flag_clear_read};
                basic_timer_pkg::dma_request_enable_addr:
                    next_prdata = {30'h0, dma_en};
                basic_timer_pkg::prescale_value_addr:
                    next_prdata = {16'h0000, prescale_value};
                default: next_pslverr = 1'b1;
            endcase
        end
        // Hardware set wins over a simultaneous clear
        if (wrap) begin
            next_flags[basic_timer_pkg::wrap_bit] = 1'b1;
        end
        if (trig_start) begin
            next_flags[basic_timer_pkg::trigger_bit] = 1'b1;
        end
        if (top) begin
            next_flags[basic_timer_pkg::top_bit] = 1'b1;
        end
        if (wrap && ctrl.single_run_select) begin
            next_ctrl.run = 1'b0;
        end
        next_dma_wrap = wrap & dma_en[0];
        next_dma_trig = trig_start & dma_en[1];
        next_out_a = next_ctrl.complementary_out_enable & next_tog;
        next_out_b = next_ctrl.complementary_out_enable & ~next_tog;
    end

    // Each interrupt is its flag gated by its enable bit, so the level
    // stays up until software clears the flag or the enable.
    logic [2:0] next_irq;
    for (genvar b = 0; b < 3; b++) begin : g_irq
        assign next_irq[b] = next_flags[b] & irq_enable[b];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            reload_limit <= basic_timer_pkg::reload_limit_reset;
            count_value <= basic_timer_pkg::count_value_reset;
            filter_sel <= 3'd0;
            irq_enable <= 3'd0;
            flags <= 3'd0;
            dma_en <= 2'd0;
            prescale_value <= 16'h0000;
            pre_cnt <= 16'h0000;
            started <= 1'b0;
            tog <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            wrap_irq <= 1'b0;
            trigger_irq <= 1'b0;
            top_irq <= 1'b0;
            dma_wrap_req <= 1'b0;
            dma_trigger_req <= 1'b0;
            complementary_out_a <= 1'b0;
            complementary_out_b <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            reload_limit <= next_reload_limit;
            count_value <= next_count_value;
            filter_sel <= next_filter_sel;
            irq_enable <= next_irq_enable;
            flags <= next_flags;
            dma_en <= next_dma_en;
            prescale_value <= next_prescale_value;
            pre_cnt <= next_pre_cnt;
            started <= next_started;
            tog <= next_tog;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            wrap_irq <= next_irq[basic_timer_pkg::wrap_bit];
            trigger_irq <= next_irq[basic_timer_pkg::trigger_bit];
            top_irq <= next_irq[basic_timer_pkg::top_bit];
            dma_wrap_req <= next_dma_wrap;
            dma_trigger_req <= next_dma_trig;
            complementary_out_a <= next_out_a;
            complementary_out_b <= next_out_b;
        end
    end
endmodule : basic_timer

// >>> design/basic_timer_pkg.sv
// Package with register map, field layout and reset values of the timer
// Notes on behaviour
// - Counter holds while run bit is 0, advances while it is 1.
// - Mode 00: plain timer counting on the bus clock.
// - Mode 01: event counter clocked by the selected trigger source.
// - Mode 10: bus clock counting starts after an active trigger edge.
// - Mode 11: bus clock counting only while the pin is active.
// - Source select 0 picks the pin, 1 picks the cascade input.
// - Polarity 0: rising edge or high level; 1: falling or low.
// - Single-run bit 0 counts continuously, 1 counts one pass.
// - Output enable 0 drives both outputs low, 1 drives opposite levels.
// - Pin filter passes a level after N equal samples at chosen rate.
// - Bus clock ticks divide by prescale plus one.
// - Trigger source ticks divide by the prescale value itself.
// - Reload limit is read-write and resets to its maximum.
// - Count register is read-write at any time, resets to zero.
// - Enable bit 0 gates the reload overflow interrupt.
// - Enable bit 1 gates the trigger interrupt.
// - Enable bit 2 gates the top overflow interrupt.
// - Read-only flags record reload overflow, trigger and top overflow.
// - Writing 0 to a clear bit clears its flag; bits read as 1.
// - DMA requests on reload overflow and trigger start when enabled.
package basic_timer_pkg;
    localparam logic [7:0] reload_limit_addr = 8'h00;
    localparam logic [7:0] count_value_addr = 8'h04;
    localparam logic [7:0] filter_control_addr = 8'h0c;
    localparam logic [7:0] basic_control_addr = 8'h10;
    localparam logic [7:0] irq_enable_addr = 8'h14;
    localparam logic [7:0] event_flags_addr = 8'h18;
    localparam logic [7:0] event_flag_clear_addr = 8'h1c;
    localparam logic [7:0] dma_request_enable_addr = 8'h20;
    localparam logic [7:0] prescale_value_addr = 8'h24;

    localparam logic [15:0] reload_limit_reset = 16'hffff;
    localparam logic [15:0] count_value_reset = 16'h0000;
    localparam logic [2:0] flag_clear_read = 3'h7;

    localparam int run_bit = 0;
    localparam int mode_lsb = 1;
    localparam int source_bit = 3;
    localparam int polarity_bit = 4;
    localparam int single_bit = 5;
    localparam int out_enable_bit = 6;
    localparam int filter_lsb = 4;
    localparam int wrap_bit = 0;
    localparam int trigger_bit = 1;
    localparam int top_bit = 2;

    localparam logic [3:0] slow_div4 = 4'h3;
    localparam logic [3:0] slow_div16 = 4'hf;

    typedef enum logic [1:0] {
        mode_timer = 2'b00,
        mode_counter = 2'b01,
        mode_trigger = 2'b10,
        mode_gated = 2'b11
    } count_mode_t;

    typedef struct packed {
        logic complementary_out_enable;
        logic single_run_select;
        logic edge_level_select;
        logic source_select;
        count_mode_t mode;
        logic run;
    } basic_control_t;
endpackage : basic_timer_pkg

// >>> bench/basic_timer_props.sv
// Port-level properties of the basic timer, bound to its top module
module basic_timer_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_trigger_pin,
    input wire logic cascade_input,
    input wire logic complementary_out_a,
    input wire logic complementary_out_b,
    input wire logic wrap_irq,
    input wire logic trigger_irq,
    input wire logic top_irq,
    input wire logic dma_wrap_req,
    input wire logic dma_trigger_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_access_one_wait:
        assert property (psel && penable && !pready |=> pready)
        else $error("Access not answered after one wait state");
    a_ready_single:
        assert property (pready |=> !pready)
        else $error("Ready held longer than one cycle");
    a_ready_from_access:
        assert property ($rose(pready) |-> $past(psel && penable) && psel)
        else $error("Ready without an access phase");
    a_error_with_ready:
        assert property (pslverr |-> pready)
        else $error("Error response outside ready cycle");
    a_data_idle_zero:
        assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("Read data not zero outside ready cycle");
    a_outs_never_both:
        assert property (!(complementary_out_a && complementary_out_b))
        else $error("Both toggle outputs high");
    a_wrap_irq_holds:
        assert property (wrap_irq && !(psel && pwrite) |=> wrap_irq)
        else $error("Wrap interrupt dropped without a write");
    a_top_irq_holds:
        assert property ($fell(top_irq) |-> $past(psel) && $past(pwrite))
        else $error("Top interrupt dropped without a write");
    a_trig_dma_single:
        assert property (dma_trigger_req |=> !dma_trigger_req [*2])
        else $error("Trigger request longer than one pulse");

    cover property (dma_wrap_req);
    cover property (pslverr);
    cover property (trigger_irq);
    cover property (top_irq);
endmodule : basic_timer_props

bind basic_timer basic_timer_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trigger_pin(ext_trigger_pin),
    .cascade_input(cascade_input),
    .complementary_out_a(complementary_out_a),
    .complementary_out_b(complementary_out_b), .wrap_irq(wrap_irq),
    .trigger_irq(trigger_irq), .top_irq(top_irq),
    .dma_wrap_req(dma_wrap_req), .dma_trigger_req(dma_trigger_req)
);

// >>> bench/basic_timer_tb_top.sv
// Self-checking bench for the basic timer
module basic_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, casc;
    logic out_a, out_b, wrap_irq, trigger_irq, top_irq, dma_wrap, dma_trig;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] gap = 32'h0000_0000;
    logic [32:0] rd_q[$];
    logic [31:0] gap_q[$];
    int failures, tests_run;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
    logic [31:0] rm [7] = '{32'h0000_ffff, 32'h0000_ffff, 32'h0000_0070,
        32'h0000_007e, 32'h0000_0007, 32'h0000_0003, 32'h0000_ffff};
    logic [7:0] ctl [5] = '{8'h03, 8'h13, 8'h0b, 8'h03, 8'h03};
    logic [7:0] flt [5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h70};
    int wid [5] = '{4, 4, 4, 8, 40};
    int cnt [5] = '{3, 3, 3, 3, 0};

    basic_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trigger_pin(pin), .cascade_input(casc),
        .complementary_out_a(out_a), .complementary_out_b(out_b),
        .wrap_irq(wrap_irq), .trigger_irq(trigger_irq), .top_irq(top_irq),
        .dma_wrap_req(dma_wrap), .dma_trigger_req(dma_trig));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic lost();
        failures++;
        stop_test();
    endtask : lost

    // Setup, then access phase held until ready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) lost();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        xfer(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic await(input logic trig);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((trig ? dma_trig : dma_wrap) !== 1'b1 && n < 3000);
        if ((trig ? dma_trig : dma_wrap) !== 1'b1) lost();
        @(posedge pclk);
    endtask : await

    // Unselected source carries noise so that only the selected one counts
    task automatic pulses(input logic src, input int w);
        repeat (12) begin
            casc <= src ? ~casc : 1'($urandom);
            pin <= src ? 1'($urandom) : ~pin;
            repeat (w) @(posedge pclk);
        end
    endtask : pulses

    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) begin
            check({pslverr, prdata}, rd_q.pop_front());
        end
        gap <= gap + 32'h0000_0001;
        if (dma_wrap === 1'b1) begin
            gap <= 32'h0000_0001;
            if (gap_q.size() > 0) begin
                check({1'b0, gap}, {1'b0, gap_q.pop_front()});
            end
        end
    end

    initial begin
        int p, l;
        logic [31:0] v;
        failures = 0;
        tests_run = 0;
        {presetn, psel, penable, pwrite, pin, casc} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        void'($urandom(23));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h00, 33'h0_0000_ffff);
        rd(8'h04, 33'h0_0000_0000);
        rd(8'h1c, 33'h0_0000_0007);
        rd(8'h08, 33'h1_0000_0000);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 33'h0_0000_0000);
        for (int i = 0; i < 7; i++) begin
            v = $urandom() & rm[i];
            wr(ra[i], v);
            rd(ra[i], {1'b0, v});
            wr(ra[i], 32'h0000_0000);
        end
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 0 : $urandom_range(3, 1);
            l = $urandom_range(5, 2);
            wr(8'h24, 32'(p));
            wr(8'h00, 32'(l));
            wr(8'h20, 32'h0000_0001);
            wr(8'h14, 32'h0000_0001);
            wr(8'h04, 32'h0000_0000);
            wr(8'h10, 32'h0000_0041);
            await(1'b0);
            gap_q.push_back(32'((l + 1) * (p + 1)));
            await(1'b0);
            check({32'h0, out_a ^ out_b}, 33'h1);
            check({32'h0, wrap_irq}, 33'h1);
            wr(8'h14, 32'h0000_0000);
            check({32'h0, wrap_irq}, 33'h0);
            wr(8'h10, 32'h0000_0000);
            wr(8'h1c, 32'h0000_0000);
            rd(8'h18, 33'h0);
            check({31'h0, out_a, out_b}, 33'h0);
        end
        wr(8'h04, 32'h0000_0000);
        wr(8'h10, 32'h0000_0021);
        await(1'b0);
        rd(8'h10, 33'h0_0000_0020);
        wr(8'h00, 32'h0000_ffff);
        wr(8'h14, 32'h0000_0004);
        wr(8'h04, 32'h0000_fffd);
        wr(8'h10, 32'h0000_0001);
        repeat (30) @(posedge pclk);
        check({32'h0, top_irq}, 33'h1);
        wr(8'h24, 32'h0000_0002);
        for (int i = 0; i < 5; i++) begin
            wr(8'h10, {24'h0, ctl[i] & 8'hfe});
            wr(8'h0c, {24'h0, flt[i]});
            wr(8'h04, 32'h0000_0000);
            wr(8'h10, {24'h0, ctl[i]});
            pulses(ctl[i][3], wid[i]);
            pin <= 1'b0;
            casc <= 1'b0;
            repeat (120) @(posedge pclk);
            rd(8'h04, {1'b0, 32'(cnt[i])});
        end
        wr(8'h10, 32'h0000_0000);
        wr(8'h24, 32'h0000_0000);
        wr(8'h0c, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            wr(8'h10, {27'h0, i[0], 4'h6});
            pin <= i[0];
            wr(8'h04, 32'h0000_0000);
            wr(8'h10, {27'h0, i[0], 4'h7});
            repeat (20) @(posedge pclk);
            rd(8'h04, 33'h0);
            pin <= ~i[0];
            repeat (20) @(posedge pclk);
            pin <= i[0];
            repeat (10) @(posedge pclk);
            rd(8'h04, 33'h0_0000_0014);
        end
        wr(8'h10, 32'h0000_0000);
        pin <= 1'b0;
        wr(8'h14, 32'h0000_0002);
        wr(8'h20, 32'h0000_0002);
        wr(8'h04, 32'h0000_0000);
        wr(8'h10, 32'h0000_0004);
        wr(8'h10, 32'h0000_0005);
        repeat (20) @(posedge pclk);
        rd(8'h04, 33'h0);
        check({32'h0, trigger_irq}, 33'h0);
        pin <= 1'b1;
        await(1'b1);
        repeat (2) @(posedge pclk);
        check({32'h0, trigger_irq}, 33'h1);
        stop_test();
    end
endmodule : basic_timer_tb_top
